// >>> hdl/nic_pkg.sv
// Shared types, offsets and constants of the nested interrupt controller.
// Assumes one clock domain and a CPU core that stalls on request.
package nic_pkg;

  // ----------------------------------------------------------------
  // Vector layout
  // ----------------------------------------------------------------
  localparam int NUM_VEC = 14;
  localparam int NUM_GRP = 4;
  localparam int GRP_PINS = 4;
  localparam int NUM_PINS = 16;
  localparam int EXT_FIRST = 2;
  localparam logic [13:0] EXT_MASK = 14'h003C;
  localparam logic [13:0] PERIPH_MASK = 14'h2FC2;
  localparam logic [13:0] HALT_WAKE_MASK = 14'h207F;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_TLI = 16'hFFFA;

  // ----------------------------------------------------------------
  // Priority and stack
  // ----------------------------------------------------------------
  localparam logic [1:0] PRIO_L0 = 2'h2;
  localparam logic [1:0] PRIO_L3 = 2'h3;
  localparam int CC_I1_POS = 5;
  localparam int CC_I0_POS = 3;
  localparam logic [7:0] SP_PAGE = 8'h01;
  localparam logic [7:0] SP_RST = 8'hFF;
  localparam logic [2:0] PUSH_LAST = 3'h4;
  localparam logic [7:0] ISP_RST = 8'hFF;
  localparam logic [7:0] ISP3_RO = 8'hF0;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADR_W = 8;
  localparam logic [7:0] ADR_ISP0 = 8'h00;
  localparam logic [7:0] ADR_ISP1 = 8'h04;
  localparam logic [7:0] ADR_ISP2 = 8'h08;
  localparam logic [7:0] ADR_ISP3 = 8'h0C;
  localparam logic [7:0] ADR_EXT_EN = 8'h10;
  localparam logic [7:0] ADR_TLI_CTL = 8'h14;
  localparam logic [7:0] ADR_VEC_EN = 8'h18;
  localparam logic [7:0] ADR_STATUS = 8'h1C;
  localparam logic [7:0] ADR_STACK = 8'h20;
  localparam int TLI_EN_BIT = 0;
  localparam int TLI_RISE_BIT = 1;
  localparam logic [13:0] VEC_EN_RST = 14'h3FFE;
  localparam int STAT_HALT_POS = 2;
  localparam int STAT_WAIT_POS = 3;
  localparam int STAT_TLI_POS = 4;
  localparam int STAT_TRAP_POS = 5;
  localparam int STAT_PEND_POS = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_RUN = 6'h01,
    ST_PUSH = 6'h02,
    ST_VEC = 6'h04,
    ST_POP = 6'h08,
    ST_HALT = 6'h10,
    ST_WAIT = 6'h20
  } state_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] x;
    logic [7:0] a;
    logic [7:0] cc;
  } ctx_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  typedef struct packed {
    state_t state;
    logic [1:0] prio;
    logic [1:0] tgt;
    logic [7:0] sp;
    logic [2:0] cnt;
    logic [15:0] vaddr;
    logic [3:0] last_vec;
    ctx_t ctx;
    logic [13:0] pend;
    logic tli_pend;
    logic trap_pend;
    logic [3:0][7:0] isp;
    logic [15:0] ext_en;
    logic [13:0] vec_en;
    logic tli_en;
    logic tli_rise;
    logic tli_s1;
    logic tli_s2;
    logic tli_s3;
    logic [15:0] ext_s1;
    logic [15:0] ext_s2;
    logic [3:0] grp_d;
    logic ack;
    logic [31:0] rdat;
    mem_req_t mem;
    logic hold;
    logic pc_load;
    logic ctx_load;
  } st_t;

  // Encoded priority bits to numeric level
  function automatic logic [1:0] lvl_of(input logic [1:0] bits);
    unique case (bits)
      2'h2: lvl_of = 2'h0;
      2'h1: lvl_of = 2'h1;
      2'h0: lvl_of = 2'h2;
      default: lvl_of = 2'h3;
    endcase
  endfunction

endpackage

// >>> hdl/prio_arbiter.sv
// Picks the winning maskable vector by software then hardware priority.
// Assumes pending, enable and priority fields come from the same clock.
`timescale 1ns/1ns
`default_nettype none
module prio_arbiter #(
  parameter int NV = nic_pkg::NUM_VEC
) (
  input wire logic [NV-1:0] pend_i,
  input wire logic [NV-1:0] allow_i,
  input wire logic [NV-1:0][1:0] prio_i,
  input wire logic [1:0] cur_i,
  output logic valid_o,
  output logic [3:0] idx_o,
  output logic [1:0] prio_o
);

  // ----------------------------------------------------------------
  // Search
  // ----------------------------------------------------------------
  logic [1:0] best;

  always_comb begin
    valid_o = 1'b0;
    idx_o = 4'h0;
    prio_o = 2'h0;
    best = 2'h0;
    for (int i = NV - 1; i >= 1; i--) begin
      if (pend_i[i] && allow_i[i] &&
          nic_pkg::lvl_of(prio_i[i]) > nic_pkg::lvl_of(cur_i) &&
          (!valid_o || nic_pkg::lvl_of(prio_i[i]) >= best)) begin
        valid_o = 1'b1;
        idx_o = 4'(i);
        prio_o = prio_i[i];
        best = nic_pkg::lvl_of(prio_i[i]);
      end
    end
  end

endmodule
`default_nettype wire

// >>> hdl/nested_priority_interrupt_controller.sv
// Nested interrupt controller: latching, arbitration, entry and return.
// Assumes a CPU that stalls on cpu_hold_o and an async-read stack memory.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Four nesting levels; only strictly higher level preempts a routine.
// - Sixteen fixed vectors in top memory, ordered by hardware priority.
// - Current level lives in condition code bits 5 and 3.
// - Level codes: 0=10, 1=01, 2=00, 3=11; level 3 masks all maskable.
// - Current instruction completes before entry starts.
// - Entry saves PC, X, A and condition codes on the stack.
// - Five bytes, PC low first at stack pointer, pointer decrements.
// - After stacking, level bits load from the vector's priority field.
// - PC loads from the vector and the routine starts there.
// - Return pops all saved registers including both level bits.
// - Highest software level wins; ties go to hardware order.
// - Unserved requests stay latched until they become the winner.
// - Reset, trap and top pin beat everything, ignoring level bits.
// - Non-maskable entry stacks (not reset), sets level 3; only the top pin entry leaves halt, trap does not.
// - Top pin interrupt fires on the selected pin edge.
// - Trap instruction raises a non-maskable entry like the top pin.
// - Reset has top hardware priority and starts at level 3.
// - Maskable served only when enabled and above current level.
// - Pin edges latch, clear on entry; pins of a group are ORed.
// - Peripheral request needs both its flag and its enable.
// - Peripheral clear sequence drops the latch and pending request.
// - Any source ends wait; only capable sources end halt.
// - First service after halt chosen among halt-capable requests.
// - Non-capable pending requests are arbitrated again once that first entry completes, and may preempt that routine.
// - Writing the level 0 code to a priority field is ignored.
module nested_priority_interrupt_controller (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [nic_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic top_level_pin_irq_i,
  input wire logic [nic_pkg::NUM_PINS-1:0] ext_pins_i,
  input wire logic [nic_pkg::NUM_VEC-1:0] periph_flag_i,
  input wire logic [nic_pkg::NUM_VEC-1:0] periph_en_i,
  input wire logic [nic_pkg::NUM_VEC-1:0] periph_clr_i,
  input wire logic instr_end_i,
  input wire logic trap_i,
  input wire logic return_from_isr_i,
  input wire logic halt_req_i,
  input wire logic wait_req_i,
  input wire logic cc_wr_i,
  input wire nic_pkg::ctx_t cpu_ctx_i,
  input wire logic [7:0] mem_rdata_i,
  output nic_pkg::mem_req_t mem_o,
  output logic cpu_hold_o,
  output logic pc_load_o,
  output logic ctx_load_o,
  output nic_pkg::ctx_t ctx_o,
  output logic [1:0] prio_bit_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  nic_pkg::st_t s;
  nic_pkg::st_t n;

  logic [31:0] isp_flat;
  logic [nic_pkg::NUM_VEC-1:0] allow;
  logic arb_valid;
  logic [3:0] arb_idx;
  logic [1:0] arb_prio;
  logic [nic_pkg::NUM_GRP-1:0] grp;
  logic [nic_pkg::NUM_VEC-1:0] ext_set;
  logic [nic_pkg::NUM_VEC-1:0] per_set;
  logic tli_edge;
  logic nmi_req;
  logic take;
  logic [1:0] fld;

  assign isp_flat = s.isp;

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // halt-capable only while halted
  assign allow = s.vec_en &
    ((s.state == nic_pkg::ST_HALT) ? nic_pkg::HALT_WAKE_MASK : '1);

  prio_arbiter #(
    .NV(nic_pkg::NUM_VEC)
  ) u_arb (
    .pend_i(s.pend),
    .allow_i(allow),
    .prio_i(isp_flat[2*nic_pkg::NUM_VEC-1:0]),
    .cur_i(s.prio),
    .valid_o(arb_valid),
    .idx_o(arb_idx),
    .prio_o(arb_prio)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    take = 1'b0;
    fld = 2'h0;
    n.ack = 1'b0;
    n.pc_load = 1'b0;
    n.ctx_load = 1'b0;

    // Pin synchronisers
    n.tli_s1 = top_level_pin_irq_i;
    n.tli_s2 = s.tli_s1;
    n.tli_s3 = s.tli_s2;
    n.ext_s1 = ext_pins_i;
    n.ext_s2 = s.ext_s1;

    tli_edge = s.tli_en &
      (s.tli_rise ? (s.tli_s2 & ~s.tli_s3) : (~s.tli_s2 & s.tli_s3));

    // OR enabled pins, latch rising edge
    ext_set = '0;
    for (int g = 0; g < nic_pkg::NUM_GRP; g++) begin
      grp[g] = |(s.ext_s2[g*nic_pkg::GRP_PINS +: nic_pkg::GRP_PINS] &
                 s.ext_en[g*nic_pkg::GRP_PINS +: nic_pkg::GRP_PINS]);
      n.grp_d[g] = grp[g];
      ext_set[nic_pkg::EXT_FIRST+g] = grp[g] & ~s.grp_d[g];
    end

    per_set = periph_flag_i & periph_en_i & nic_pkg::PERIPH_MASK;

    n.pend = s.pend & ~(periph_clr_i & nic_pkg::PERIPH_MASK);

    nmi_req = s.trap_pend | s.tli_pend;

    // Software write of condition codes
    if (cc_wr_i) begin
      n.prio = {cpu_ctx_i.cc[nic_pkg::CC_I1_POS], cpu_ctx_i.cc[nic_pkg::CC_I0_POS]};
    end

    // --------------------------------------------------------------
    // Register bus
    // --------------------------------------------------------------
    if (wb_cyc_i && wb_stb_i && !s.ack) begin
      n.ack = 1'b1;
      n.rdat = '0;
      unique case (wb_adr_i)
        nic_pkg::ADR_ISP0, nic_pkg::ADR_ISP1, nic_pkg::ADR_ISP2, nic_pkg::ADR_ISP3: begin
          if (wb_we_i && wb_sel_i[0]) begin
            for (int f = 0; f < 4; f++) begin
              fld = wb_dat_i[2*f +: 2];
              if (fld != nic_pkg::PRIO_L0) begin
                n.isp[wb_adr_i[3:2]][2*f +: 2] = fld;
              end
            end
            n.isp[3] = n.isp[3] | nic_pkg::ISP3_RO;
          end
          n.rdat[7:0] = s.isp[wb_adr_i[3:2]];
        end
        nic_pkg::ADR_EXT_EN: begin
          if (wb_we_i && wb_sel_i[0]) begin
            n.ext_en[7:0] = wb_dat_i[7:0];
          end
          if (wb_we_i && wb_sel_i[1]) begin
            n.ext_en[15:8] = wb_dat_i[15:8];
          end
          n.rdat[15:0] = s.ext_en;
        end
        nic_pkg::ADR_TLI_CTL: begin
          if (wb_we_i && wb_sel_i[0]) begin
            n.tli_en = wb_dat_i[nic_pkg::TLI_EN_BIT];
            n.tli_rise = wb_dat_i[nic_pkg::TLI_RISE_BIT];
          end
          n.rdat[nic_pkg::TLI_EN_BIT] = s.tli_en;
          n.rdat[nic_pkg::TLI_RISE_BIT] = s.tli_rise;
        end
        nic_pkg::ADR_VEC_EN: begin
          if (wb_we_i && wb_sel_i[0]) begin
            n.vec_en[7:0] = wb_dat_i[7:0];
          end
          if (wb_we_i && wb_sel_i[1]) begin
            n.vec_en[13:8] = wb_dat_i[13:8];
          end
          n.vec_en[0] = 1'b0;
          n.rdat[13:0] = s.vec_en;
        end
        nic_pkg::ADR_STATUS: begin
          n.rdat[1:0] = s.prio;
          n.rdat[nic_pkg::STAT_HALT_POS] = (s.state == nic_pkg::ST_HALT);
          n.rdat[nic_pkg::STAT_WAIT_POS] = (s.state == nic_pkg::ST_WAIT);
          n.rdat[nic_pkg::STAT_TLI_POS] = s.tli_pend;
          n.rdat[nic_pkg::STAT_TRAP_POS] = s.trap_pend;
          n.rdat[nic_pkg::STAT_PEND_POS +: nic_pkg::NUM_VEC] = s.pend;
        end
        nic_pkg::ADR_STACK: begin
          n.rdat[15:0] = {nic_pkg::SP_PAGE, s.sp};
          n.rdat[19:16] = s.last_vec;
        end
        default: begin
          n.rdat = '0;
        end
      endcase
    end

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    unique case (s.state)
      nic_pkg::ST_RUN: begin
        if (return_from_isr_i) begin
          n.state = nic_pkg::ST_POP;
          n.cnt = 3'h0;
          n.hold = 1'b1;
        end else if (halt_req_i) begin
          n.state = nic_pkg::ST_HALT;
          n.prio = nic_pkg::PRIO_L0;
          n.hold = 1'b1;
        end else if (wait_req_i) begin
          n.state = nic_pkg::ST_WAIT;
          n.prio = nic_pkg::PRIO_L0;
          n.hold = 1'b1;
        end else if (instr_end_i && (nmi_req || arb_valid)) begin
          take = 1'b1;
        end
      end
      nic_pkg::ST_HALT: begin
        if (s.tli_pend || arb_valid) begin
          take = 1'b1;
        end
      end
      nic_pkg::ST_WAIT: begin
        if (nmi_req || arb_valid) begin
          take = 1'b1;
        end else if (|s.pend) begin
          n.state = nic_pkg::ST_RUN;
          n.hold = 1'b0;
        end
      end
      nic_pkg::ST_PUSH: begin
        n.sp = s.sp - 8'h01;
        n.cnt = s.cnt + 3'h1;
        if (s.cnt == nic_pkg::PUSH_LAST) begin
          n.state = nic_pkg::ST_VEC;
          n.cnt = 3'h0;
          n.prio = s.tgt;
        end
      end
      nic_pkg::ST_VEC: begin
        if (s.cnt == 3'h0) begin
          n.ctx.pc[15:8] = mem_rdata_i;
          n.cnt = 3'h1;
        end else begin
          n.ctx.pc[7:0] = mem_rdata_i;
          n.pc_load = 1'b1;
          n.hold = 1'b0;
          n.state = nic_pkg::ST_RUN;
        end
      end
      nic_pkg::ST_POP: begin
        n.sp = s.sp + 8'h01;
        n.cnt = s.cnt + 3'h1;
        unique case (s.cnt)
          3'h0: begin
            n.ctx.cc = mem_rdata_i;
            n.prio = {mem_rdata_i[nic_pkg::CC_I1_POS], mem_rdata_i[nic_pkg::CC_I0_POS]};
          end
          3'h1: n.ctx.a = mem_rdata_i;
          3'h2: n.ctx.x = mem_rdata_i;
          3'h3: n.ctx.pc[15:8] = mem_rdata_i;
          default: n.ctx.pc[7:0] = mem_rdata_i;
        endcase
        if (s.cnt == nic_pkg::PUSH_LAST) begin
          n.ctx_load = 1'b1;
          n.hold = 1'b0;
          n.state = nic_pkg::ST_RUN;
        end
      end
      default: begin
        n.state = nic_pkg::ST_RUN;
        n.hold = 1'b0;
      end
    endcase

    // --------------------------------------------------------------
    // Entry
    // --------------------------------------------------------------
    if (take) begin
      n.state = nic_pkg::ST_PUSH;
      n.cnt = 3'h0;
      n.hold = 1'b1;
      // level sits in bits 5 and 3
      n.ctx = cpu_ctx_i;
      n.ctx.cc[nic_pkg::CC_I1_POS] = s.prio[1];
      n.ctx.cc[nic_pkg::CC_I0_POS] = s.prio[0];
      if (s.trap_pend && s.state != nic_pkg::ST_HALT) begin
        n.trap_pend = 1'b0;
        n.vaddr = nic_pkg::VEC_TRAP;
        n.tgt = nic_pkg::PRIO_L3;
        n.last_vec = 4'hF;
      end else if (s.tli_pend) begin
        n.tli_pend = 1'b0;
        n.vaddr = nic_pkg::VEC_TLI;
        n.tgt = nic_pkg::PRIO_L3;
        n.last_vec = 4'h0;
      end else begin
        n.vaddr = nic_pkg::VEC_TLI - {11'h000, arb_idx, 1'b0};
        n.tgt = arb_prio;
        n.last_vec = arb_idx;
        if (nic_pkg::EXT_MASK[arb_idx]) begin
          n.pend[arb_idx] = 1'b0;
        end
      end
    end

    n.pend = n.pend | ext_set | per_set;
    n.tli_pend = n.tli_pend | tli_edge;
    n.trap_pend = n.trap_pend | trap_i;

    // --------------------------------------------------------------
    // Memory request
    // --------------------------------------------------------------
    n.mem = '0;
    if (n.state == nic_pkg::ST_PUSH) begin
      n.mem.we = 1'b1;
      n.mem.addr = {nic_pkg::SP_PAGE, n.sp};
      unique case (n.cnt)
        3'h0: n.mem.wdata = n.ctx.pc[7:0];
        3'h1: n.mem.wdata = n.ctx.pc[15:8];
        3'h2: n.mem.wdata = n.ctx.x;
        3'h3: n.mem.wdata = n.ctx.a;
        default: n.mem.wdata = n.ctx.cc;
      endcase
    end else if (n.state == nic_pkg::ST_VEC) begin
      n.mem.re = 1'b1;
      n.mem.addr = n.vaddr + {13'h0000, n.cnt};
    end else if (n.state == nic_pkg::ST_POP) begin
      n.mem.re = 1'b1;
      n.mem.addr = {nic_pkg::SP_PAGE, n.sp + 8'h01};
    end

    // --------------------------------------------------------------
    // Reset
    // --------------------------------------------------------------
    if (rst_i) begin
      n = '0;
      n.state = nic_pkg::ST_VEC;
      n.prio = nic_pkg::PRIO_L3;
      n.tgt = nic_pkg::PRIO_L3;
      n.vaddr = nic_pkg::VEC_RESET;
      n.sp = nic_pkg::SP_RST;
      n.isp = {4{nic_pkg::ISP_RST}};
      n.vec_en = nic_pkg::VEC_EN_RST;
      n.last_vec = 4'hE;
      n.hold = 1'b1;
      n.mem.re = 1'b1;
      n.mem.addr = nic_pkg::VEC_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    s <= n;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_dat_o = s.rdat;
  assign wb_ack_o = s.ack;
  assign mem_o = s.mem;
  assign cpu_hold_o = s.hold;
  assign pc_load_o = s.pc_load;
  assign ctx_load_o = s.ctx_load;
  assign ctx_o = s.ctx;
  assign prio_bit_o = s.prio;

endmodule
`default_nettype wire

// >>> tb/nic_mem_model.sv
// Stack and vector memory beside the controller.
// Assumes one access a cycle; reads are combinational.
`timescale 1ns/1ns
`default_nettype none
module nic_mem_model (
  input wire logic clk_i,
  input wire nic_pkg::mem_req_t mem_i,
  output logic [7:0] rdata_o
);
  logic [7:0] m [0:65535];
  logic tog;
  // --------------------------------
  // Vector table: routine hi, lo 5A
  // --------------------------------
  initial begin
    tog = 1'b0;
    for (int i = 16'hFFE0; i <= 16'hFFFF; i++) begin
      m[i] = i[0] ? 8'h5A : {3'h4, i[4:0]};
    end
  end
  always_ff @(posedge clk_i) begin
    tog <= ~tog;
    if (mem_i.we) begin
      m[mem_i.addr] <= mem_i.wdata;
    end
  end
  // Unselected bus shows a changing pattern
  assign rdata_o = mem_i.re ? m[mem_i.addr] : {8{tog}};
endmodule
`default_nettype wire

// >>> tb/nic_asserts.sv
// Checker of entry, return and bus timing.
// Assumes binding to the controller top module.
`timescale 1ns/1ns
`default_nettype none
module nic_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire nic_pkg::ctx_t cpu_ctx_i,
  input wire nic_pkg::mem_req_t mem_o,
  input wire logic cpu_hold_o,
  input wire logic pc_load_o,
  input wire logic ctx_load_o,
  input wire logic [1:0] prio_bit_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
  property p_push_five;
    $rose(mem_o.we) |-> mem_o.we [*5] ##1 mem_o.re;
  endproperty
  a_push_five: assert property (p_push_five) else $error("push not five bytes");
  property p_push_dec;
    mem_o.we && $past(mem_o.we) |-> mem_o.addr[7:0] == $past(mem_o.addr[7:0]) - 8'h01;
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("stack not decrementing");
  property p_pcl_first;
    $rose(mem_o.we) |-> mem_o.wdata == $past(cpu_ctx_i.pc[7:0]) && mem_o.addr[15:8] == nic_pkg::SP_PAGE;
  endproperty
  a_pcl_first: assert property (p_pcl_first) else $error("first push not PC low");
  property p_vec_top;
    pc_load_o |-> $past(mem_o.addr[15:5]) == 11'h7FF;
  endproperty
  a_vec_top: assert property (p_vec_top) else $error("vector outside top area");
  property p_nmi_l3;
    pc_load_o && ($past(mem_o.addr) == 16'hFFFB || $past(mem_o.addr) == 16'hFFFD) |-> prio_bit_o == 2'h3;
  endproperty
  a_nmi_l3: assert property (p_nmi_l3) else $error("nmi level not 3");
  property p_rst_l3;
    $fell(rst_i) |-> ##[1:3] pc_load_o && prio_bit_o == nic_pkg::PRIO_L3;
  endproperty
  a_rst_l3: assert property (p_rst_l3) else $error("reset entry wrong");
  property p_hold_span;
    $rose(mem_o.we) |-> cpu_hold_o [*7] ##1 (pc_load_o && !cpu_hold_o);
  endproperty
  a_hold_span: assert property (p_hold_span) else $error("entry length wrong");
  property p_pop_end;
    $rose(ctx_load_o) |-> $past(mem_o.re) && !cpu_hold_o;
  endproperty
  a_pop_end: assert property (p_pop_end) else $error("return not after pops");
endmodule
bind nested_priority_interrupt_controller nic_asserts i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cpu_ctx_i(cpu_ctx_i), .mem_o(mem_o), .cpu_hold_o(cpu_hold_o),
  .pc_load_o(pc_load_o), .ctx_load_o(ctx_load_o), .prio_bit_o(prio_bit_o));
`default_nettype wire

// >>> tb/nested_priority_interrupt_controller_test.sv
// Bench: registers, arbitration, nesting, nmi and halt.
// Assumes the memory model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module nested_priority_interrupt_controller_test;
  logic clk_i, rst_i, cyc, stb, we, ie, trap, ret, halt, wt, ccw, pin, ack, hold, pcl, ctl;
  logic [7:0] adr, mrd;
  logic [31:0] dat, rd, wdo;
  logic [15:0] pins;
  logic [13:0] flg, en, clr;
  logic [1:0] lvl;
  logic [39:0] pk;
  nic_pkg::ctx_t ctx, ctx_q;
  nic_pkg::mem_req_t mem;
  int n_fail, num_checks, cyc_cnt;
  nested_priority_interrupt_controller i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack),
    .top_level_pin_irq_i(pin), .ext_pins_i(pins), .periph_flag_i(flg), .periph_en_i(en), .periph_clr_i(clr),
    .instr_end_i(ie), .trap_i(trap), .return_from_isr_i(ret), .halt_req_i(halt), .wait_req_i(wt),
    .cc_wr_i(ccw), .cpu_ctx_i(ctx), .mem_rdata_i(mrd), .mem_o(mem), .cpu_hold_o(hold), .pc_load_o(pcl),
    .ctx_load_o(ctl), .ctx_o(ctx_q), .prio_bit_o(lvl));
  nic_mem_model i_mem (.clk_i(clk_i), .mem_i(mem), .rdata_o(mrd));
  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rd = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic step;
    ie <= 1'b1;
    @(posedge clk_i);
    ie <= 1'b0;
  endtask
  task automatic take(input logic [15:0] v, input logic [1:0] l);
    @(posedge clk_i);
    while (pcl !== 1'b1) @(posedge clk_i);
    chk(ctx_q.pc, {3'h4, v[4:0], 8'h5A});
    chk(lvl, l);
  endtask
  task automatic back;
    ret <= 1'b1;
    @(posedge clk_i);
    ret <= 1'b0;
    while (ctl !== 1'b1) @(posedge clk_i);
    chk(ctx_q[39:8], ctx[39:8]);
    @(posedge clk_i);
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // --------------------------------
  // Clock and timeout
  // --------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  // --------------------------------
  // Tests
  // --------------------------------
  initial begin
    {cyc, stb, we, ie, trap, ret, halt, wt, ccw, pin} = '0;
    {adr, dat, pins, flg, en, clr} = '0;
    n_fail = 0;
    num_checks = 0;
    cyc_cnt = 0;
    ctx = {16'h1234, 8'h56, 8'h78, 8'h20};
    pk = {8'h20, 8'h78, 8'h56, 8'h12, 8'h34};
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    take(nic_pkg::VEC_RESET, 2'h3);
    wb(1'b0, nic_pkg::ADR_VEC_EN, 32'h0);
    chk(rd, 32'h3FFE);
    wb(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, nic_pkg::ADR_ISP0, 32'hCF);
    wb(1'b1, nic_pkg::ADR_ISP0, 32'h64);
    wb(1'b0, nic_pkg::ADR_ISP0, 32'h0);
    chk(rd, 32'h44);
    wb(1'b1, nic_pkg::ADR_ISP3, 32'h0);
    wb(1'b0, nic_pkg::ADR_ISP3, 32'h0);
    chk(rd, 32'hF0);
    wb(1'b1, nic_pkg::ADR_ISP1, 32'h7F);
    wb(1'b1, nic_pkg::ADR_ISP2, 32'hF4);
    ccw <= 1'b1;
    @(posedge clk_i);
    ccw <= 1'b0;
    @(posedge clk_i);
    chk(lvl, 2'h2);
    $display("test registers done");
    en <= 14'h0380;
    flg <= 14'h0180;
    @(posedge clk_i);
    step;
    take(16'hFFEA, 2'h0);
    for (int i = 0; i < 5; i++) begin
      chk(i_mem.m[16'(16'h01FF - i)], pk[8*i +: 8]);
    end
    clr <= 14'h0100;
    flg <= 14'h0080;
    @(posedge clk_i);
    clr <= '0;
    back;
    chk(lvl, 2'h2);
    step;
    take(16'hFFEC, 2'h1);
    flg <= 14'h0680;
    step;
    repeat (12) @(posedge clk_i);
    wb(1'b0, nic_pkg::ADR_STACK, 32'h0);
    chk(rd[19:0], 20'h701FA);
    $display("test arbitration done");
    wb(1'b1, nic_pkg::ADR_TLI_CTL, 32'h3);
    pin <= 1'b1;
    repeat (6) @(posedge clk_i);
    step;
    take(nic_pkg::VEC_TLI, 2'h3);
    back;
    chk(lvl, 2'h1);
    trap <= 1'b1;
    @(posedge clk_i);
    trap <= 1'b0;
    step;
    take(nic_pkg::VEC_TRAP, 2'h3);
    back;
    $display("test nmi done");
    flg <= 14'h0600;
    clr <= 14'h0080;
    @(posedge clk_i);
    clr <= '0;
    back;
    wb(1'b1, nic_pkg::ADR_ISP0, 32'h54);
    wb(1'b1, nic_pkg::ADR_ISP2, 32'hF0);
    wb(1'b1, nic_pkg::ADR_EXT_EN, 32'h1);
    halt <= 1'b1;
    @(posedge clk_i);
    halt <= 1'b0;
    repeat (10) @(posedge clk_i);
    wb(1'b0, nic_pkg::ADR_STATUS, 32'h0);
    chk(rd[nic_pkg::STAT_HALT_POS], 1'b1);
    pins <= 16'h0001;
    take(16'hFFF6, 2'h1);
    step;
    take(16'hFFE8, 2'h0);
    $display("test halt done");
    wt <= 1'b1;
    @(posedge clk_i);
    wt <= 1'b0;
    take(16'hFFE8, 2'h0);
    $display("test wait done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
